// ==== inc/pa_regs.svh ====
// Register map, field positions and reset values of the pulse accumulator flag and port block.
// Assumes an AXI4-Lite host with 32-bit data; every register takes one aligned word at four times its index.
// Functional notes
// RULE1: Overflow flag sets when the 16-bit count wraps from 0xFFFF to 0x0000.
// RULE2: Overflow interrupt request is high while overflow flag and its enable are set.
// RULE3: Writing one clears the overflow flag; zero leaves it; readable and writable anytime.
// RULE4: Event counting mode sets the input flag on the selected active pin edge.
// RULE5: Gated mode sets the input flag on the trailing edge of the gate level.
// RULE6: Input interrupt request is high while input flag and its enable are set.
// RULE7: Writing one clears the input flag; writing zero has no effect.
// RULE8: With fast clear enabled, any count register access clears both flags.
// RULE9: Count register holds counted events since reset; readable and writable anytime.
// RULE10: Accumulator input is synchronised to the bus clock, so reads may lag an edge.
// RULE11: Software reads the count as one 16-bit access for a coherent value.
// RULE12: Port data register has four pin bits low; upper bits are reserved.
// RULE13: Written port data is latched and drives a pin only as general output.
// RULE14: Port read returns pin level where direction is zero, latch where one.
// RULE15: Port data write never changes a pin driven by a timer output function.
// RULE16: Reset clears all four direction bits so every pin starts as input.
// RULE17: Direction bit one makes an output, zero an input; readable and writable anytime.
// RULE18: Mode bit one selects gated time accumulation, zero selects event counting.
// RULE19: Gated mode counts the divide-by-64 prescaler tick, absent while timer inactive.
// RULE20: A flag set and a clear in the same cycle leave the flag set.
`ifndef PA_REGS_SVH
`define PA_REGS_SVH

`define PA_ADDR_W 26
`define PA_PINS 4
`define PA_SYNC_W 5
// Register indices; the byte address is the index shifted left by two.
`define PA_IDX_FLAG 24'h1a_0019
`define PA_IDX_CNT 24'h1a_001a
`define PA_IDX_PORT 24'h1a_001b
`define PA_IDX_DDR 24'h1a_001c
`define PA_IDX_CTRL 24'h1a_001d
`define PA_ADDR_FLAG {`PA_IDX_FLAG, 2'b00}
`define PA_ADDR_CNT {`PA_IDX_CNT, 2'b00}
`define PA_ADDR_PORT {`PA_IDX_PORT, 2'b00}
`define PA_ADDR_DDR {`PA_IDX_DDR, 2'b00}
`define PA_ADDR_CTRL {`PA_IDX_CTRL, 2'b00}
// Flag register fields.
`define PA_FLG_OVF 1
`define PA_FLG_IN 0
// Control register fields.
`define PA_CTL_FAST 7
`define PA_CTL_EN 6
`define PA_CTL_MODE 5
`define PA_CTL_EDGE 4
`define PA_CTL_OVI 1
`define PA_CTL_INI 0
// Reset values.
`define PA_RST_CTRL 8'h00
`define PA_RST_DDR 4'h0
`define PA_RST_LATCH 4'h0
`define PA_RST_CNT 16'h0000
`define PA_CNT_MAX 16'hffff
// Divide ratio of the external gated-mode tick, for reference only.
`define PA_GATE_DIV 64
// Bus responses.
`define PA_RESP_OKAY 2'b00
`define PA_RESP_DECERR 2'b11

`endif

// ==== inc/pa_pkg.sv ====
// Types shared by the pulse accumulator flag and port block.
// Assumes pa_regs.svh is on the include path.
`include "pa_regs.svh"

package pa_pkg;

    typedef enum {SEL_FLAG, SEL_CNT, SEL_PORT, SEL_DDR, SEL_CTRL, SEL_NONE} reg_sel_t;

    typedef struct packed {
        logic aw_held;
        logic [`PA_ADDR_W-1:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [15:0] count;
        logic ovf;
        logic inf;
        logic [7:0] ctrl;
        logic [`PA_PINS-1:0] latch;
        logic [`PA_PINS-1:0] ddr;
    } pa_state_t;

    typedef struct packed {
        logic [`PA_SYNC_W-1:0] st1;
        logic [`PA_SYNC_W-1:0] st2;
        logic [`PA_SYNC_W-1:0] st3;
    } sync_state_t;

endpackage

// ==== inc/pa_sync_if.sv ====
// Carries raw pin levels into the synchroniser and clean levels and edges back out.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
`include "pa_regs.svh"

interface pa_sync_if;
    logic raw_pai;
    logic [`PA_PINS-1:0] raw_pins;
    logic s_pai;
    logic [`PA_PINS-1:0] s_pins;
    logic pai_rise;
    logic pai_fall;

    modport sync (input raw_pai, input raw_pins, output s_pai, output s_pins, output pai_rise, output pai_fall);
    modport user (output raw_pai, output raw_pins, input s_pai, input s_pins, input pai_rise, input pai_fall);
endinterface

// ==== design/pa_pin_sync.sv ====
// Two-stage synchroniser for the accumulator input and the port pins, with an edge detector on the accumulator input only.
// Assumes asynchronous pin levels and one system clock.
`timescale 1ns/1ps

module pa_pin_sync
    import pa_pkg::*;
(
    input wire logic sys_clk,
    input wire logic arst_n,
    pa_sync_if.sync pins
);
    sync_state_t q;
    sync_state_t d;

    // The first stage feeds only the second; edges are taken between stages two and three.
    always_comb begin
        d = q;
        d.st1 = {pins.raw_pai, pins.raw_pins}; // RULE10
        d.st2 = q.st1;
        d.st3 = q.st2;
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Clean levels and one-cycle edge pulses.
    assign pins.s_pai = q.st2[`PA_SYNC_W-1];
    assign pins.s_pins = q.st2[`PA_PINS-1:0];
    assign pins.pai_rise = q.st2[`PA_SYNC_W-1] & ~q.st3[`PA_SYNC_W-1];
    assign pins.pai_fall = ~q.st2[`PA_SYNC_W-1] & q.st3[`PA_SYNC_W-1];

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    a_sync_two_stage: assert property ($rose(pins.raw_pai) ##1 pins.raw_pai ##1 pins.raw_pai |-> pins.s_pai) // RULE10
        else $error("Accumulator input not seen two cycles after it rose.");
    a_rise_single: assert property (pins.pai_rise |=> !pins.pai_rise)
        else $error("Rise pulse lasted more than one cycle.");
endmodule

// ==== design/pulse_accum_flags_port.sv ====
// Flag, count and port-pin registers of the pulse accumulator, with an AXI4-Lite slave.
// Assumes the prescaler supplies a one-cycle divide-by-64 tick only while the timer runs, and that
// the output compare logic tells which pins it owns and at which level, all on sys_clk.
`timescale 1ns/1ps

module pulse_accum_flags_port
    import pa_pkg::*;
(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [`PA_ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [`PA_ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic accum_input_pin,
    input wire logic [`PA_PINS-1:0] port_pin_in,
    output logic [`PA_PINS-1:0] port_pin_out,
    output logic [`PA_PINS-1:0] port_pin_oe,
    input wire logic [`PA_PINS-1:0] timer_out_active,
    input wire logic [`PA_PINS-1:0] timer_out_level,
    input wire logic div64_tick,
    output logic overflow_irq,
    output logic input_irq
);
    pa_state_t q;
    pa_state_t d;
    pa_sync_if sync_bus ();

    logic wr_go;
    reg_sel_t wr_sel;
    reg_sel_t rd_sel;
    logic rd_go;
    logic fast_clr;
    logic ovf_clr;
    logic in_clr;
    logic cnt_wr;
    logic cnt_inc;
    logic ovf_set;
    logic ev_set;
    logic gt_set;
    logic in_set;
    logic gate_on;
    logic act_edge;
    logic [`PA_PINS-1:0] port_view;

    // Address decode shared by the read and write paths; anything else answers with a decode error.
    function automatic reg_sel_t reg_sel(input logic [`PA_ADDR_W-1:0] a);
        reg_sel_t s;
        s = SEL_NONE;
        if (a == `PA_ADDR_FLAG) begin
            s = SEL_FLAG;
        end else if (a == `PA_ADDR_CNT) begin
            s = SEL_CNT;
        end else if (a == `PA_ADDR_PORT) begin
            s = SEL_PORT;
        end else if (a == `PA_ADDR_DDR) begin
            s = SEL_DDR;
        end else if (a == `PA_ADDR_CTRL) begin
            s = SEL_CTRL;
        end
        return s;
    endfunction

    // Pins reach the counting logic only through the synchroniser.
    assign sync_bus.raw_pai = accum_input_pin;
    assign sync_bus.raw_pins = port_pin_in;

    pa_pin_sync u_sync (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .pins(sync_bus)
    );

    // Channel readiness: one write and one read at a time, each blocked while its answer waits.
    assign awready = !q.aw_held && !q.bvalid;
    assign wready = !q.w_held && !q.bvalid;
    assign arready = !q.rvalid;
    assign bvalid = q.bvalid;
    assign bresp = q.bresp;
    assign rvalid = q.rvalid;
    assign rresp = q.rresp;
    assign rdata = q.rdata;

    // Decoded access strobes.
    assign wr_go = q.aw_held && q.w_held && !q.bvalid;
    assign wr_sel = reg_sel(q.aw_addr);
    assign rd_go = arvalid && arready;
    assign rd_sel = reg_sel(araddr);

    // Any touch of the count register, read or write, whole or partial, counts as an access.
    assign fast_clr = q.ctrl[`PA_CTL_FAST] && ((wr_go && wr_sel == SEL_CNT) || (rd_go && rd_sel == SEL_CNT)); // RULE8
    assign ovf_clr = (wr_go && wr_sel == SEL_FLAG && q.w_strb[0] && q.w_data[`PA_FLG_OVF]) || fast_clr; // RULE3
    assign in_clr = (wr_go && wr_sel == SEL_FLAG && q.w_strb[0] && q.w_data[`PA_FLG_IN]) || fast_clr; // RULE7
    assign cnt_wr = wr_go && wr_sel == SEL_CNT;

    // The gate level is low when the edge bit is set, high otherwise.
    assign gate_on = q.ctrl[`PA_CTL_EDGE] ? !sync_bus.s_pai : sync_bus.s_pai;
    // The active event edge and the trailing gate edge coincide for both settings of the edge bit.
    assign act_edge = q.ctrl[`PA_CTL_EDGE] ? sync_bus.pai_rise : sync_bus.pai_fall;
    assign ev_set = q.ctrl[`PA_CTL_EN] && !q.ctrl[`PA_CTL_MODE] && act_edge; // RULE4
    assign gt_set = q.ctrl[`PA_CTL_EN] && q.ctrl[`PA_CTL_MODE] && act_edge; // RULE5
    assign in_set = ev_set || gt_set;

    // Event mode counts edges; gated mode counts prescaler ticks while the gate is open.
    // With no timer running there is no tick, so gated counting simply stops.
    always_comb begin
        cnt_inc = 1'b0;
        if (q.ctrl[`PA_CTL_EN]) begin
            if (q.ctrl[`PA_CTL_MODE]) begin // RULE18
                cnt_inc = div64_tick && gate_on; // RULE19
            end else begin
                cnt_inc = act_edge;
            end
        end
    end

    // A software write wins over an increment in the same cycle; that one count is dropped.
    assign ovf_set = cnt_inc && !cnt_wr && q.count == `PA_CNT_MAX; // RULE1

    // Input pins show their live level, output pins the latch.
    assign port_view = (q.ddr & q.latch) | (~q.ddr & sync_bus.s_pins); // RULE14

    // Next state of the bus slave and of every register.
    always_comb begin
        d = q;
        // Write address and data are taken independently, in either order.
        if (awvalid && awready) begin
            d.aw_held = 1'b1;
            d.aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            d.w_held = 1'b1;
            d.w_data = wdata;
            d.w_strb = wstrb;
        end
        if (wr_go) begin
            d.aw_held = 1'b0;
            d.w_held = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = (wr_sel == SEL_NONE) ? `PA_RESP_DECERR : `PA_RESP_OKAY;
            if (wr_sel == SEL_PORT && q.w_strb[0]) begin
                d.latch = q.w_data[`PA_PINS-1:0]; // RULE13
            end else if (wr_sel == SEL_DDR && q.w_strb[0]) begin
                d.ddr = q.w_data[`PA_PINS-1:0]; // RULE17
            end else if (wr_sel == SEL_CTRL && q.w_strb[0]) begin
                d.ctrl = q.w_data[7:0];
            end
        end
        if (q.bvalid && bready) begin
            d.bvalid = 1'b0;
        end
        // Reads are answered one cycle after the address is taken, from a register.
        if (rd_go) begin
            d.rvalid = 1'b1;
            d.rresp = `PA_RESP_OKAY;
            d.rdata = 32'h0000_0000;
            if (rd_sel == SEL_FLAG) begin
                d.rdata[`PA_FLG_OVF] = q.ovf;
                d.rdata[`PA_FLG_IN] = q.inf;
            end else if (rd_sel == SEL_CNT) begin
                d.rdata[15:0] = q.count; // RULE9
            end else if (rd_sel == SEL_PORT) begin
                d.rdata[`PA_PINS-1:0] = port_view; // RULE12
            end else if (rd_sel == SEL_DDR) begin
                d.rdata[`PA_PINS-1:0] = q.ddr;
            end else if (rd_sel == SEL_CTRL) begin
                d.rdata[7:0] = q.ctrl;
            end else begin
                d.rresp = `PA_RESP_DECERR;
            end
        end
        if (q.rvalid && rready) begin
            d.rvalid = 1'b0;
        end
        // Counter: byte lanes let software load either half, though whole-word access keeps it coherent.
        if (cnt_wr) begin
            if (q.w_strb[0]) begin
                d.count[7:0] = q.w_data[7:0]; // RULE9
            end
            if (q.w_strb[1]) begin
                d.count[15:8] = q.w_data[15:8];
            end
        end else if (cnt_inc) begin
            d.count = q.count + 16'h0001;
        end
        // Flags: a set in the same cycle as any clear keeps the flag.
        d.ovf = (q.ovf && !ovf_clr) || ovf_set; // RULE20
        d.inf = (q.inf && !in_clr) || in_set; // RULE20
    end

    // One register bank; reset leaves every pin not owned by a timer output an input and every flag clear.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0; // RULE16
        end else begin
            q <= d;
        end
    end

    // Interrupt requests are plain levels of flag and enable.
    assign overflow_irq = q.ovf && q.ctrl[`PA_CTL_OVI]; // RULE2
    assign input_irq = q.inf && q.ctrl[`PA_CTL_INI]; // RULE6

    // A timer output owns its pin; the latch shows only once the pin returns to general output.
    assign port_pin_out = (timer_out_active & timer_out_level) | (~timer_out_active & q.latch); // RULE15
    assign port_pin_oe = timer_out_active | q.ddr; // RULE17

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    a_ovf_wrap: assert property (cnt_inc && !cnt_wr && q.count == 16'hffff |=> q.ovf && q.count == 16'h0000) // RULE1
        else $error("Count wrap did not raise the overflow flag.");
    a_ovf_irq_level: assert property (overflow_irq == (q.ovf && q.ctrl[`PA_CTL_OVI])) // RULE2
        else $error("Overflow request does not follow flag and enable.");
    a_ovf_w1c: assert property (wr_go && wr_sel == SEL_FLAG && q.w_strb[0] && q.w_data[1] && !ovf_set |=> !q.ovf) // RULE3
        else $error("Writing one did not clear the overflow flag.");
    a_ovf_w0_keeps: assert property (q.ovf && !ovf_clr |=> q.ovf) // RULE3
        else $error("Overflow flag dropped without a clear.");
    a_evt_flag: assert property (q.ctrl[6] && !q.ctrl[5] && act_edge |=> q.inf) // RULE4
        else $error("Active edge in event mode did not set the input flag.");
    a_gate_flag: assert property (q.ctrl[6] && q.ctrl[5] && $fell(gate_on) |=> q.inf) // RULE5
        else $error("Gate trailing edge did not set the input flag.");
    a_in_irq_level: assert property (q.inf && q.ctrl[`PA_CTL_INI] |-> input_irq) // RULE6
        else $error("Input request missing while flag and enable set.");
    a_in_w1c: assert property (wr_go && wr_sel == SEL_FLAG && q.w_strb[0] && q.w_data[0] && !in_set |=> !q.inf) // RULE7
        else $error("Writing one did not clear the input flag.");
    a_fast_clear: assert property (fast_clr && !ovf_set && !in_set |=> !q.ovf && !q.inf) // RULE8
        else $error("Count access with fast clear left a flag set.");
    a_set_wins: assert property (in_set && in_clr |=> q.inf) // RULE20
        else $error("Input flag lost an event to a clear.");
    a_pin_drive: assert property (((port_pin_out ^ q.latch) & ~timer_out_active & q.ddr) == 4'h0) // RULE13
        else $error("General output pin does not show the latch.");
    a_port_read: assert property (rd_go && rd_sel == SEL_PORT |=> rdata[3:0] == $past(port_view) && rdata[31:4] == 28'h0) // RULE14
        else $error("Port read returned the wrong view.");
    a_gated_count: assert property (q.ctrl[6] && q.ctrl[5] && !div64_tick && !cnt_wr |=> q.count == $past(q.count)) // RULE19
        else $error("Gated count moved without a prescaler tick.");

    c_overflow: cover property (ovf_set);
    c_gate_flag: cover property (gt_set);
    c_fast_clear: cover property (fast_clr && q.ovf);
    c_back_to_back_write: cover property (wr_go ##2 wr_go);
endmodule

// ==== dv/pa_pin_model.sv ====
// Model of the far side: pulse source on the accumulator pin, prescaler tick and port pin wires.
// Assumes the bench calls its tasks from one process, each starting just after a clock edge.
`timescale 1ns/1ps
`include "pa_regs.svh"

module pa_pin_model (
    input wire logic sys_clk,
    input wire logic [`PA_PINS-1:0] pin_out,
    input wire logic [`PA_PINS-1:0] pin_oe,
    output logic [`PA_PINS-1:0] pin_in,
    output logic accum_pin,
    output logic tick
);
    logic [`PA_PINS-1:0] ext = '0;

    initial begin
        accum_pin = 1'b0;
        tick = 1'b0;
    end

    // A driven pin shows the block's level; an undriven one shows the outside level.
    always_comb pin_in = (pin_oe & pin_out) | (~pin_oe & ext);

    // Pulse of w cycles; w above two keeps it wider than the synchroniser can miss.
    task automatic pulse(input int w);
        accum_pin <= 1'b1;
        repeat (w) @(posedge sys_clk);
        accum_pin <= 1'b0;
        repeat (w) @(posedge sys_clk);
    endtask

    // Hold the gate at lvl and give n divide-by-64 ticks; ticks exist only while the timer runs.
    task automatic gate(input logic lvl, input int n);
        accum_pin <= lvl;
        repeat (4) @(posedge sys_clk);
        repeat (n) begin
            tick <= 1'b1;
            @(posedge sys_clk);
            tick <= 1'b0;
            repeat (63) @(posedge sys_clk);
        end
        accum_pin <= ~lvl;
        repeat (6) @(posedge sys_clk);
    endtask
endmodule

// ==== dv/tb_pulse_accum_flags_port.sv ====
// Self-checking bench for the accumulator flag and port block, acting as AXI4-Lite master.
// Assumes reads answer with rvalid, writes with bvalid; read data are checked by a monitor process.
`timescale 1ns/1ps
`include "pa_regs.svh"

module tb_pulse_accum_flags_port;
    import pa_pkg::*;
    typedef struct {string nm; logic [31:0] d; logic [1:0] r;} exp_t;
    exp_t exp_q[$];
    exp_t e;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [`PA_ADDR_W-1:0] awaddr = '0;
    logic [`PA_ADDR_W-1:0] araddr = '0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid, ovf_irq, in_irq, accum_input_pin_or_irq_enable, tick;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, r;
    logic [3:0] pin_in, pin_out, pin_oe;
    logic [3:0] t_act = 4'h0;
    logic [3:0] t_lvl = 4'h0;
    int bad_count = 0;
    int tests_run = 0;
    localparam logic [`PA_ADDR_W-1:0] ADDR_BAD = {24'h1a_001e, 2'b00};

    always #2.5 sys_clk = ~sys_clk;

    pulse_accum_flags_port i_dut (.sys_clk(sys_clk), .arst_n(arst_n), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .accum_input_pin(accum_input_pin_or_irq_enable),
        .port_pin_in(pin_in), .port_pin_out(pin_out), .port_pin_oe(pin_oe), .timer_out_active(t_act),
        .timer_out_level(t_lvl), .div64_tick(tick), .overflow_irq(ovf_irq), .input_irq(in_irq));

    pa_pin_model i_src (.sys_clk(sys_clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in),
        .accum_pin(accum_input_pin_or_irq_enable), .tick(tick));

    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] y);
        tests_run++;
        if (x !== y) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, x, y);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Write one word; both channels offered together and each released once taken.
    // Local flags track what is still pending, since the valid signals only change after this time step.
    // The response ready stays high between writes, so it is never lowered and raised in one step.
    task automatic wr(input logic [`PA_ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] rs);
        logic aw_p;
        logic w_p;
        aw_p = 1'b1;
        w_p = 1'b1;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (aw_p || w_p) begin
            @(posedge sys_clk);
            if (aw_p && awready) begin
                awvalid <= 1'b0;
                aw_p = 1'b0;
            end
            if (w_p && wready) begin
                wvalid <= 1'b0;
                w_p = 1'b0;
            end
        end
        do @(posedge sys_clk); while (!bvalid);
        chk("bresp", {30'h0, rs}, {30'h0, bresp});
    endtask

    // Read one word; the expected result is queued for the monitor.
    // The read data ready stays high afterwards, so back-to-back reads never drive it twice in one step.
    task automatic rd(input string nm, input logic [`PA_ADDR_W-1:0] a, input logic [31:0] d,
        input logic [1:0] rs);
        exp_q.push_back('{nm, d, rs});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge sys_clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge sys_clk); while (!rvalid);
    endtask

    // Monitor: each accepted read answer is matched against the oldest queued note.
    always @(posedge sys_clk) begin
        if (rvalid && rready) begin
            if (exp_q.size() == 0) begin
                chk("unexpected_read", 32'h0, 32'h1);
            end else begin
                e = exp_q.pop_front();
                chk(e.nm, e.d, rdata);
                chk({e.nm, "_resp"}, {30'h0, e.r}, {30'h0, rresp});
            end
        end
    end

    // Watchdog sized well above the few hundred cycles the sequence needs.
    initial begin
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        tally_and_finish();
    end

    initial begin
        void'($urandom(32'hcc0c));
        repeat (12) @(posedge sys_clk);
        arst_n <= 1'b1;
        @(posedge sys_clk);
        rd("ddr_rst", `PA_ADDR_DDR, 32'h0, `PA_RESP_OKAY);
        rd("cnt_rst", `PA_ADDR_CNT, 32'h0, `PA_RESP_OKAY);
        rd("flag_rst", `PA_ADDR_FLAG, 32'h0, `PA_RESP_OKAY);
        // Port: random direction, latch and outside levels; reads mix pin and latch per bit.
        r = $urandom();
        wr(`PA_ADDR_DDR, {28'hfff_ffff, r[3:0]}, `PA_RESP_OKAY);
        wr(`PA_ADDR_PORT, {28'hfff_ffff, r[7:4]}, `PA_RESP_OKAY);
        i_src.ext <= r[11:8];
        repeat (4) @(posedge sys_clk);
        rd("ddr", `PA_ADDR_DDR, {28'h0, r[3:0]}, `PA_RESP_OKAY);
        rd("port", `PA_ADDR_PORT, {28'h0, (r[7:4] & r[3:0]) | (r[11:8] & ~r[3:0])}, `PA_RESP_OKAY);
        chk("pin_oe", {28'h0, r[3:0]}, {28'h0, pin_oe});
        chk("pin_out", {28'h0, r[7:4] & r[3:0]}, {28'h0, pin_out & pin_oe});
        // Timer owns two pins: a port write must not move them, but the latch keeps it.
        t_act <= 4'b0101;
        t_lvl <= r[15:12];
        wr(`PA_ADDR_PORT, {28'h0, ~r[7:4]}, `PA_RESP_OKAY);
        chk("pin_timer", {28'h0, (r[15:12] & 4'b0101) | (~r[7:4] & 4'b1010)}, {28'h0, pin_out});
        t_act <= 4'b0000;
        @(posedge sys_clk);
        chk("pin_latch", {28'h0, ~r[7:4]}, {28'h0, pin_out});
        // Event mode, rising edge, from the top of the count: wraps and sets both flags.
        wr(`PA_ADDR_CNT, 32'h0000_ffff, `PA_RESP_OKAY);
        wr(`PA_ADDR_CTRL, 32'h0000_0053, `PA_RESP_OKAY);
        i_src.pulse(4);
        rd("cnt_wrap", `PA_ADDR_CNT, 32'h0, `PA_RESP_OKAY);
        rd("flag_both", `PA_ADDR_FLAG, 32'h3, `PA_RESP_OKAY);
        chk("ovf_irq", 32'h1, {31'h0, ovf_irq});
        chk("in_irq", 32'h1, {31'h0, in_irq});
        wr(`PA_ADDR_FLAG, 32'h0, `PA_RESP_OKAY);
        rd("flag_w0", `PA_ADDR_FLAG, 32'h3, `PA_RESP_OKAY);
        wr(`PA_ADDR_FLAG, 32'h2, `PA_RESP_OKAY);
        rd("flag_w_ovf", `PA_ADDR_FLAG, 32'h1, `PA_RESP_OKAY);
        chk("ovf_irq_off", 32'h0, {31'h0, ovf_irq});
        wr(`PA_ADDR_FLAG, 32'h1, `PA_RESP_OKAY);
        rd("flag_w_in", `PA_ADDR_FLAG, 32'h0, `PA_RESP_OKAY);
        chk("in_irq_off", 32'h0, {31'h0, in_irq});
        // Falling edge selected, then fast clear: a count read empties the flags.
        wr(`PA_ADDR_CTRL, 32'h0000_0043, `PA_RESP_OKAY);
        i_src.pulse(4);
        wr(`PA_ADDR_CTRL, 32'h0000_00c3, `PA_RESP_OKAY);
        rd("cnt_fall", `PA_ADDR_CNT, 32'h1, `PA_RESP_OKAY);
        rd("flag_fast", `PA_ADDR_FLAG, 32'h0, `PA_RESP_OKAY);
        // Gated mode, high gate: three ticks counted, the falling trailing edge sets the flag.
        wr(`PA_ADDR_CTRL, 32'h0000_0060, `PA_RESP_OKAY);
        wr(`PA_ADDR_CNT, 32'h0, `PA_RESP_OKAY);
        i_src.gate(1'b1, 3);
        rd("cnt_gate", `PA_ADDR_CNT, 32'h3, `PA_RESP_OKAY);
        rd("flag_gate", `PA_ADDR_FLAG, 32'h1, `PA_RESP_OKAY);
        // Unmapped place answers with a decode error and reads as zero.
        wr(ADDR_BAD, 32'hffff_ffff, `PA_RESP_DECERR);
        rd("unmapped", ADDR_BAD, 32'h0, `PA_RESP_DECERR);
        rd("port_hi", `PA_ADDR_PORT, {28'h0, (~r[7:4] & r[3:0]) | (r[11:8] & ~r[3:0])}, `PA_RESP_OKAY);
        repeat (4) @(posedge sys_clk);
        tally_and_finish();
    end
endmodule
